// [shct_mul_sat.sv]
// Registered signed multiply, arithmetic shift and saturation to 24 bits.
// Assumes inputs on the same clock; clr drops the stage contents.
`timescale 1ns/1ps
`default_nettype none

module shct_mul_sat #(
    parameter int SHIFT = 0
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        clr,
    // Sample in
    input  wire logic        in_valid,
    input  wire logic [23:0] in_data,
    input  wire logic [17:0] factor,
    // Sample out
    output logic             out_valid,
    output logic [23:0]      out_data,
    output logic             out_sat
);
    logic signed [42:0] prod;
    logic signed [42:0] scaled;
    logic               fits;

    assign prod   = $signed(in_data) * $signed({1'b0, factor});
    assign scaled = prod >>> SHIFT;
    assign fits   = (&scaled[42:23]) | ~(|scaled[42:23]);

    always_ff @(posedge sys_clk) begin
        if (sys_rst || clr) begin
            out_valid <= 1'b0;
            out_data  <= shct_pkg::SHCT_DATA_RST;
            out_sat   <= 1'b0;
        end else begin
            out_valid <= in_valid;
            out_sat   <= in_valid & ~fits;
            if (in_valid) begin
                if (fits)
                    out_data <= scaled[23:0];
                else if (scaled[42])
                    out_data <= shct_pkg::SHCT_SAT_MIN;
                else
                    out_data <= shct_pkg::SHCT_SAT_MAX;
            end
        end
    end
endmodule // shct_mul_sat

`default_nettype wire

// [shct_offset_sub.sv]
// Registered signed subtraction of the offset trim with saturation.
// Assumes inputs on the same clock; clr drops the stage contents.
`timescale 1ns/1ps
`default_nettype none

module shct_offset_sub (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        clr,
    // Sample in
    input  wire logic        in_valid,
    input  wire logic [23:0] in_data,
    input  wire logic [23:0] offset,
    // Sample out
    output logic             out_valid,
    output logic [23:0]      out_data,
    output logic             out_sat
);
    logic [24:0] diff;
    logic        fits;

    assign diff = {in_data[23], in_data} - {offset[23], offset};
    assign fits = diff[24] == diff[23];

    always_ff @(posedge sys_clk) begin
        if (sys_rst || clr) begin
            out_valid <= 1'b0;
            out_data  <= shct_pkg::SHCT_DATA_RST;
            out_sat   <= 1'b0;
        end else begin
            out_valid <= in_valid;
            out_sat   <= in_valid & ~fits;
            if (in_valid) begin
                if (fits)
                    out_data <= diff[23:0];
                else if (diff[24])
                    out_data <= shct_pkg::SHCT_SAT_MIN;
                else
                    out_data <= shct_pkg::SHCT_SAT_MAX;
            end
        end
    end
endmodule // shct_offset_sub

`default_nettype wire

// [shct_pkg.sv]
// Constants for the shunt converter setup and trim block.
// Assumes one 50 MHz clock and a register port with 8-bit addresses.
`default_nettype none

package shct_pkg;
    localparam logic [7:0]  SHCT_SETUP_OFS    = 8'h83;
    localparam logic [7:0]  SHCT_OFS_HI_OFS   = 8'h84;
    localparam logic [7:0]  SHCT_OFS_LO_OFS   = 8'h85;
    localparam logic [7:0]  SHCT_GTRIM_OFS    = 8'h86;
    localparam logic [7:0]  SHCT_STATUS_OFS   = 8'hf0;
    localparam logic [7:0]  SHCT_DATA_HI_OFS  = 8'hf1;
    localparam logic [7:0]  SHCT_DATA_LO_OFS  = 8'hf2;

    localparam logic [15:0] SHCT_SETUP_RST    = 16'h8010;
    localparam logic [15:0] SHCT_SETUP_WMASK  = 16'h8f3f;
    localparam logic [15:0] SHCT_OFS_HI_RST   = 16'h0000;
    localparam logic [7:0]  SHCT_OFS_LO_RST   = 8'h00;
    localparam logic [15:0] SHCT_GTRIM_RST    = 16'h0000;
    localparam logic [15:0] SHCT_RD_IDLE      = 16'h0000;

    localparam int SHCT_EN_BIT     = 15;
    localparam int SHCT_GAIN_HI    = 11;
    localparam int SHCT_GAIN_LO    = 10;
    localparam int SHCT_MUX_HI     = 9;
    localparam int SHCT_MUX_LO     = 8;
    localparam int SHCT_SRC_RT_BIT = 5;
    localparam int SHCT_SNK_RT_BIT = 4;
    localparam int SHCT_SRC_LV_HI  = 3;
    localparam int SHCT_SRC_LV_LO  = 2;
    localparam int SHCT_SNK_LV_HI  = 1;
    localparam int SHCT_SNK_LV_LO  = 0;
    localparam int SHCT_STAT_SAT   = 0;

    localparam logic [1:0]  SHCT_COUNT_RST    = 2'h0;
    localparam logic [23:0] SHCT_DATA_RST     = 24'h000000;
    localparam logic [23:0] SHCT_SAT_MAX      = 24'h7fffff;
    localparam logic [23:0] SHCT_SAT_MIN      = 24'h800000;
    localparam logic [17:0] SHCT_DGAIN_X1     = 18'h00001;
    localparam logic [17:0] SHCT_DGAIN_X2     = 18'h00002;
    localparam logic [17:0] SHCT_DGAIN_X4     = 18'h00004;
    localparam logic [17:0] SHCT_GTRIM_ONE    = 18'h10000;
    localparam int          SHCT_GTRIM_SHIFT  = 16;

    typedef enum logic [1:0] {
        SHCT_GAIN_4  = 2'b00,
        SHCT_GAIN_8  = 2'b01,
        SHCT_GAIN_16 = 2'b10,
        SHCT_GAIN_32 = 2'b11
    } shct_gain_t;

    typedef enum logic [1:0] {
        SHCT_MUX_DIRECT  = 2'b00,
        SHCT_MUX_SWAPPED = 2'b01,
        SHCT_MUX_SHORTED = 2'b10,
        SHCT_MUX_TESTDAC = 2'b11
    } shct_mux_t;
endpackage

`default_nettype wire

// [shct_setup_trim.sv]
// Shunt converter setup, input routing, open-wire control and trim path.
// Assumes raw results, power modes and the register port share sys_clk.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module shct_setup_trim (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [15:0]      reg_rdata,
    // Power modes
    input  wire logic        standby_mode,
    input  wire logic        power_down_mode,
    // Raw conversion results
    input  wire logic        raw_valid,
    input  wire logic [23:0] raw_data,
    // Corrected conversion results
    output logic             conv_valid,
    output logic [23:0]      conv_data,
    output logic [1:0]       shunt_conversion_counter,
    // Converter control
    output logic             shunt_converter_on,
    output logic             analog_gain_x8,
    // Input routing switches
    output logic             pos_in_from_pos_pin,
    output logic             neg_in_from_neg_pin,
    output logic             pos_in_from_neg_pin,
    output logic             neg_in_from_pos_pin,
    output logic             inputs_to_ground,
    output logic             inputs_to_test_dac,
    // Open-wire current steering
    output logic             source_to_pos_pin,
    output logic             source_to_neg_pin,
    output logic             sink_to_pos_pin,
    output logic             sink_to_neg_pin,
    output logic [1:0]       open_wire_source_level,
    output logic [1:0]       open_wire_sink_level
);
    // Software registers
    logic [15:0] setup_r;
    logic [15:0] ofs_hi_r;
    logic [7:0]  ofs_lo_r;
    logic [15:0] gain_trim_r;
    logic        sat_seen_r;
    logic [15:0] rdata_r;

    // Converter state
    logic [1:0]  count_r;
    logic [23:0] data_r;
    logic        valid_r;

    // Decoded fields
    logic                 conv_on;
    logic                 conv_clear;
    shct_pkg::shct_gain_t gain_sel;
    shct_pkg::shct_mux_t  mux_sel;
    logic [23:0]          offset_trim;
    logic [17:0]          dgain_factor;
    logic [17:0]          gtrim_factor;

    // Pipeline links
    logic        dg_valid;
    logic [23:0] dg_data;
    logic        dg_sat;
    logic        os_valid;
    logic [23:0] os_data;
    logic        os_sat;
    logic        gt_valid;
    logic [23:0] gt_data;
    logic        gt_sat;
    logic        any_sat;

    // Access strobes
    logic wr_setup;
    logic wr_ofs_hi;
    logic wr_ofs_lo;
    logic wr_gtrim;
    logic wr_status;

    assign wr_setup  = reg_wr && (reg_addr == shct_pkg::SHCT_SETUP_OFS);
    assign wr_ofs_hi = reg_wr && (reg_addr == shct_pkg::SHCT_OFS_HI_OFS);
    assign wr_ofs_lo = reg_wr && (reg_addr == shct_pkg::SHCT_OFS_LO_OFS);
    assign wr_gtrim  = reg_wr && (reg_addr == shct_pkg::SHCT_GTRIM_OFS);
    assign wr_status = reg_wr && (reg_addr == shct_pkg::SHCT_STATUS_OFS);

    // Field decode
    assign conv_on  = setup_r[shct_pkg::SHCT_EN_BIT];
    assign gain_sel = shct_pkg::shct_gain_t'(
        setup_r[shct_pkg::SHCT_GAIN_HI:shct_pkg::SHCT_GAIN_LO]);
    assign mux_sel  = shct_pkg::shct_mux_t'(
        setup_r[shct_pkg::SHCT_MUX_HI:shct_pkg::SHCT_MUX_LO]);

    // Disable and low-power modes flush the converter
    assign conv_clear = ~conv_on | standby_mode | power_down_mode;

    // Offset trim assembled from both halves
    assign offset_trim = {ofs_hi_r, ofs_lo_r};

    // Gain trim factor: one plus the signed trim, in 2^-16 steps
    assign gtrim_factor = shct_pkg::SHCT_GTRIM_ONE
                        + {{2{gain_trim_r[15]}}, gain_trim_r};

    // Digital share of the gain
    always_comb begin
        case (gain_sel)
            shct_pkg::SHCT_GAIN_4:  dgain_factor = shct_pkg::SHCT_DGAIN_X1;
            shct_pkg::SHCT_GAIN_8:  dgain_factor = shct_pkg::SHCT_DGAIN_X1;
            shct_pkg::SHCT_GAIN_16: dgain_factor = shct_pkg::SHCT_DGAIN_X2;
            shct_pkg::SHCT_GAIN_32: dgain_factor = shct_pkg::SHCT_DGAIN_X4;
            default:                dgain_factor = shct_pkg::SHCT_DGAIN_X1;
        endcase
    end

    // Setup register
    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            setup_r <= shct_pkg::SHCT_SETUP_RST;
        else if (wr_setup)
            setup_r <= reg_wdata & shct_pkg::SHCT_SETUP_WMASK;
    end

    // Offset trim registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ofs_hi_r <= shct_pkg::SHCT_OFS_HI_RST;
            ofs_lo_r <= shct_pkg::SHCT_OFS_LO_RST;
        end else begin
            if (wr_ofs_hi)
                ofs_hi_r <= reg_wdata;
            if (wr_ofs_lo)
                ofs_lo_r <= reg_wdata[15:8];
        end
    end

    // Gain trim register
    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            gain_trim_r <= shct_pkg::SHCT_GTRIM_RST;
        else if (wr_gtrim)
            gain_trim_r <= reg_wdata;
    end

    // Sticky saturation flag; a new event wins over a write-one clear
    assign any_sat = dg_sat | os_sat | gt_sat;

    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            sat_seen_r <= 1'b0;
        else if (any_sat)
            sat_seen_r <= 1'b1;
        else if (wr_status && reg_wdata[shct_pkg::SHCT_STAT_SAT])
            sat_seen_r <= 1'b0;
    end

    // Read data, valid only in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdata_r <= shct_pkg::SHCT_RD_IDLE;
        end else if (reg_rd) begin
            case (reg_addr)
                shct_pkg::SHCT_SETUP_OFS:   rdata_r <= setup_r;
                shct_pkg::SHCT_OFS_HI_OFS:  rdata_r <= ofs_hi_r;
                shct_pkg::SHCT_OFS_LO_OFS:  rdata_r <= {ofs_lo_r, 8'h00};
                shct_pkg::SHCT_GTRIM_OFS:   rdata_r <= gain_trim_r;
                shct_pkg::SHCT_STATUS_OFS:
                    rdata_r <= {12'h000, count_r, conv_on, sat_seen_r};
                shct_pkg::SHCT_DATA_HI_OFS: rdata_r <= data_r[23:8];
                shct_pkg::SHCT_DATA_LO_OFS: rdata_r <= {data_r[7:0], 8'h00};
                default:                    rdata_r <= shct_pkg::SHCT_RD_IDLE;
            endcase
        end else begin
            rdata_r <= shct_pkg::SHCT_RD_IDLE;
        end
    end

    assign reg_rdata = rdata_r;

    // Digital gain stage
    shct_mul_sat #(
        .SHIFT (0)
    ) dgain_u (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .clr       (conv_clear),
        .in_valid  (raw_valid & ~conv_clear),
        .in_data   (raw_data),
        .factor    (dgain_factor),
        .out_valid (dg_valid),
        .out_data  (dg_data),
        .out_sat   (dg_sat)
    );

    // Offset trim stage
    shct_offset_sub offset_u (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .clr       (conv_clear),
        .in_valid  (dg_valid),
        .in_data   (dg_data),
        .offset    (offset_trim),
        .out_valid (os_valid),
        .out_data  (os_data),
        .out_sat   (os_sat)
    );

    // Gain trim stage
    shct_mul_sat #(
        .SHIFT (shct_pkg::SHCT_GTRIM_SHIFT)
    ) gtrim_u (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .clr       (conv_clear),
        .in_valid  (os_valid),
        .in_data   (os_data),
        .factor    (gtrim_factor),
        .out_valid (gt_valid),
        .out_data  (gt_data),
        .out_sat   (gt_sat)
    );

    // Conversion data
    always_ff @(posedge sys_clk) begin
        if (sys_rst || conv_clear)
            data_r <= shct_pkg::SHCT_DATA_RST;
        else if (gt_valid)
            data_r <= gt_data;
    end

    // Conversion counter
    always_ff @(posedge sys_clk) begin
        if (sys_rst || conv_clear)
            count_r <= shct_pkg::SHCT_COUNT_RST;
        else if (gt_valid)
            count_r <= count_r + 2'h1;
    end

    // Result strobe
    always_ff @(posedge sys_clk) begin
        if (sys_rst || conv_clear)
            valid_r <= 1'b0;
        else
            valid_r <= gt_valid;
    end

    assign conv_valid               = valid_r;
    assign conv_data                = data_r;
    assign shunt_conversion_counter = count_r;

    // Converter enable and analog gain
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            shunt_converter_on <= 1'b1;
            analog_gain_x8     <= 1'b0;
        end else begin
            shunt_converter_on <= conv_on;
            analog_gain_x8     <= (gain_sel != shct_pkg::SHCT_GAIN_4);
        end
    end

    // Input routing; all switches open while the converter is off
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pos_in_from_pos_pin <= 1'b0;
            neg_in_from_neg_pin <= 1'b0;
            pos_in_from_neg_pin <= 1'b0;
            neg_in_from_pos_pin <= 1'b0;
            inputs_to_ground    <= 1'b0;
            inputs_to_test_dac  <= 1'b0;
        end else begin
            pos_in_from_pos_pin <= conv_on
                && (mux_sel == shct_pkg::SHCT_MUX_DIRECT);
            neg_in_from_neg_pin <= conv_on
                && (mux_sel == shct_pkg::SHCT_MUX_DIRECT);
            pos_in_from_neg_pin <= conv_on
                && (mux_sel == shct_pkg::SHCT_MUX_SWAPPED);
            neg_in_from_pos_pin <= conv_on
                && (mux_sel == shct_pkg::SHCT_MUX_SWAPPED);
            inputs_to_ground    <= conv_on
                && (mux_sel == shct_pkg::SHCT_MUX_SHORTED);
            inputs_to_test_dac  <= conv_on
                && (mux_sel == shct_pkg::SHCT_MUX_TESTDAC);
        end
    end

    // Open-wire source and sink steering and levels
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            source_to_pos_pin      <= 1'b0;
            source_to_neg_pin      <= 1'b0;
            sink_to_pos_pin        <= 1'b0;
            sink_to_neg_pin        <= 1'b0;
            open_wire_source_level <= 2'h0;
            open_wire_sink_level   <= 2'h0;
        end else begin
            source_to_pos_pin <= ~setup_r[shct_pkg::SHCT_SRC_RT_BIT];
            source_to_neg_pin <= setup_r[shct_pkg::SHCT_SRC_RT_BIT];
            sink_to_pos_pin   <= ~setup_r[shct_pkg::SHCT_SNK_RT_BIT];
            sink_to_neg_pin   <= setup_r[shct_pkg::SHCT_SNK_RT_BIT];
            open_wire_source_level <=
                setup_r[shct_pkg::SHCT_SRC_LV_HI:shct_pkg::SHCT_SRC_LV_LO];
            open_wire_sink_level <=
                setup_r[shct_pkg::SHCT_SNK_LV_HI:shct_pkg::SHCT_SNK_LV_LO];
        end
    end
endmodule // shct_setup_trim

`default_nettype wire

// [shct_setup_trim_properties.sv]
// Concurrent checks for the shunt converter setup and trim block.
// Bound to shct_setup_trim; sees only its ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none

module shct_setup_trim_chk (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    // Register port and power modes
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        standby_mode,
    input wire logic        power_down_mode,
    // Results and converter controls
    input wire logic        raw_valid,
    input wire logic        conv_valid,
    input wire logic [23:0] conv_data,
    input wire logic [1:0]  shunt_conversion_counter,
    input wire logic        shunt_converter_on,
    input wire logic        analog_gain_x8,
    input wire logic        inputs_to_ground,
    input wire logic        inputs_to_test_dac,
    input wire logic        source_to_neg_pin,
    input wire logic        sink_to_neg_pin,
    input wire logic [1:0]  open_wire_source_level,
    input wire logic [1:0]  open_wire_sink_level
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    logic [15:0] wd1_r;
    logic [15:0] wd2_r;
    logic        low_pwr;
    assign low_pwr = standby_mode || power_down_mode;

    // Write data two edges back, lined up with the setup outputs
    always_ff @(posedge sys_clk) begin
        wd1_r <= reg_wdata;
        wd2_r <= wd1_r;
    end

    sequence setup_wr;
        reg_wr && reg_addr == 8'h83 ##1 !(reg_wr && reg_addr == 8'h83);
    endsequence

    off_clears_data_a: assert property (!shunt_converter_on |->
        conv_data == 24'h000000 && shunt_conversion_counter == 2'h0)
        else $error("data or counter not cleared while off");
    low_power_clear_a: assert property ($past(low_pwr) |->
        conv_data == 24'h000000 && shunt_conversion_counter == 2'h0
        && !conv_valid) else $error("low power did not clear results");
    analog_gain_a: assert property (setup_wr |=>
        analog_gain_x8 == (wd2_r[11:10] != 2'b00))
        else $error("analog gain does not follow gain field");
    input_route_a: assert property (setup_wr |=>
        inputs_to_ground == (wd2_r[15] && wd2_r[9:8] == 2'b10) &&
        inputs_to_test_dac == (wd2_r[15] && wd2_r[9:8] == 2'b11))
        else $error("input routing does not follow selector");
    source_route_a: assert property (setup_wr |=>
        source_to_neg_pin == wd2_r[5]) else $error("source route wrong");
    sink_route_a: assert property (setup_wr |=>
        sink_to_neg_pin == wd2_r[4]) else $error("sink route wrong");
    open_wire_levels_a: assert property (setup_wr |=>
        {open_wire_source_level, open_wire_sink_level} == wd2_r[3:0])
        else $error("open-wire levels do not follow setup");
    result_latency_a: assert property (raw_valid && shunt_converter_on
        && !low_pwr ##1 (shunt_converter_on && !low_pwr)[*3]
        ##1 shunt_converter_on |-> conv_valid)
        else $error("result missing four cycles after raw sample");
    result_cause_a: assert property (conv_valid |-> $past(raw_valid, 4))
        else $error("result without raw sample");
    count_step_a: assert property (conv_valid |->
        shunt_conversion_counter == $past(shunt_conversion_counter) + 2'h1)
        else $error("conversion counter did not step");
    low_byte_zero_a: assert property (reg_rd && reg_addr == 8'h85 |=>
        reg_rdata[7:0] == 8'h00) else $error("offset low byte not zero");

    cover property (conv_valid && shunt_conversion_counter == 2'h3);
    cover property (setup_wr ##1 analog_gain_x8);
    cover property (power_down_mode ##1 !power_down_mode);
endmodule // shct_setup_trim_chk

bind shct_setup_trim shct_setup_trim_chk chk (
    .sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .standby_mode, .power_down_mode, .raw_valid, .conv_valid, .conv_data,
    .shunt_conversion_counter, .shunt_converter_on, .analog_gain_x8,
    .inputs_to_ground, .inputs_to_test_dac, .source_to_neg_pin,
    .sink_to_neg_pin, .open_wire_source_level, .open_wire_sink_level
);

`default_nettype wire

// [tb_shct_setup_trim.sv]
// Self-checking bench for the shunt converter setup and trim block.
// Drives every port at 50 MHz; expected results are queued by the driver.
`timescale 1ns/1ps
`default_nettype none

module tb_shct_setup_trim;
    logic        sys_clk, sys_rst, reg_wr, reg_rd, raw_valid, rd_d;
    logic        standby_mode, power_down_mode, conv_valid, on_w, gain8_w;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, gt_v, cfg;
    logic [23:0] raw_data, conv_data, off_v;
    logic [1:0]  cnt_w, src_lv_w, snk_lv_w, cnt_exp, g_v;
    logic [5:0]  sw_w, sw_e;
    logic [3:0]  ow_w;
    logic [15:0] rd_q[$];
    logic [23:0] cv_q[$];
    int          bad_count, n_tests;
    integer      seed = 32'h3073b07d;

    shct_setup_trim dut (
        .sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .standby_mode, .power_down_mode, .raw_valid, .raw_data,
        .conv_valid, .conv_data, .shunt_conversion_counter(cnt_w),
        .shunt_converter_on(on_w), .analog_gain_x8(gain8_w),
        .pos_in_from_pos_pin(sw_w[5]), .neg_in_from_neg_pin(sw_w[4]),
        .pos_in_from_neg_pin(sw_w[3]), .neg_in_from_pos_pin(sw_w[2]),
        .inputs_to_ground(sw_w[1]), .inputs_to_test_dac(sw_w[0]),
        .source_to_pos_pin(ow_w[3]), .source_to_neg_pin(ow_w[2]),
        .sink_to_pos_pin(ow_w[1]), .sink_to_neg_pin(ow_w[0]),
        .open_wire_source_level(src_lv_w), .open_wire_sink_level(snk_lv_w)
    );

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    function automatic logic [23:0] sat(input longint v);
        if (v > 64'sd8388607) return 24'h7fffff;
        if (v < -64'sd8388608) return 24'h800000;
        return v[23:0];
    endfunction

    // Digital gain, then offset, then gain trim with floor shift
    function automatic logic [23:0] exp_conv(input logic [23:0] x);
        longint m;
        m = (g_v == 2'b10) ? 2 : (g_v == 2'b11) ? 4 : 1;
        m = longint'($signed(sat(longint'($signed(x)) * m)));
        m = longint'($signed(sat(m - longint'($signed(off_v)))));
        return sat((m * (65536 + longint'($signed(gt_v)))) >>> 16);
    endfunction

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        rd_q.push_back(exp);
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
    endtask

    task automatic raw(input logic [23:0] d, input bit keep);
        @(posedge sys_clk);
        raw_valid <= 1'b1;
        raw_data  <= d;
        if (keep) cv_q.push_back(exp_conv(d));
    endtask

    task automatic idle();
        @(posedge sys_clk);
        raw_valid <= 1'b0;
    endtask

    // Result watcher: read data the cycle after a read, results on valid
    always @(posedge sys_clk) begin
        if (rd_d) check(reg_rdata, rd_q.pop_front());
        rd_d = reg_rd;
        if (conv_valid) begin
            cnt_exp = cnt_exp + 2'b01;
            check({cnt_w, conv_data}, {cnt_exp,
                  (cv_q.size() > 0) ? cv_q.pop_front() : 24'hx});
        end
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        end_of_test();
    end

    initial begin
        {sys_rst, reg_wr, reg_rd, raw_valid, standby_mode} = 5'h10;
        power_down_mode = 1'b0;
        {reg_addr, reg_wdata, raw_data} = '0;
        {rd_d, cnt_exp, g_v, off_v, gt_v} = '0;
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 check({on_w, gain8_w, sw_w, ow_w, src_lv_w, snk_lv_w},
                 {2'b10, 6'h30, 4'b1001, 4'h0});
        for (int a = 0; a < 5; a++)
            rd(8'(8'h83 + a), (a == 0) ? 16'h8010 : 16'h0000);
        wr(8'h83, 16'hffff);
        rd(8'h83, 16'h8f3f);
        wr(8'h85, 16'hffff);
        rd(8'h85, 16'hff00);
        wr(8'h90, 16'hffff);
        rd(8'h90, 16'h0000);
        for (int a = 4; a < 7; a += 2) begin
            cfg = 16'($random(seed));
            wr(8'(8'h80 + a), cfg);
            rd(8'(8'h80 + a), cfg);
        end
        // Every gain, selector, route and level code
        for (int i = 0; i < 4; i++) begin
            cfg = {4'h8, i[1:0], i[1:0], 2'b00, i[0], ~i[1], i[1:0], ~i[1:0]};
            wr(8'h83, cfg);
            repeat (2) @(posedge sys_clk);
            sw_e = (i == 0) ? 6'h30 : (i == 1) ? 6'h0c : (i == 2) ? 6'h02 : 6'h01;
            #1 check({gain8_w, sw_w, ow_w, src_lv_w, snk_lv_w},
                     {i != 0, sw_e, ~i[0], i[0], i[1], ~i[1], i[1:0],
                      ~i[1:0]});
            rd(8'h83, cfg);
        end
        // Trimmed results at every gain, back to back
        for (int i = 0; i < 4; i++) begin
            g_v = 2'(i);
            off_v = 24'($random(seed));
            gt_v = (i == 0) ? 16'h8000 : (i == 1) ? 16'h7fff :
                   (i == 2) ? 16'($random(seed)) : 16'h0000;
            wr(8'h83, {4'h8, g_v, 10'h010});
            wr(8'h84, off_v[23:8]);
            wr(8'h85, {off_v[7:0], 8'h00});
            wr(8'h86, gt_v);
            for (int k = 0; k < 6; k++)
                raw((k == 0) ? 24'h7fffff : (k == 1) ? 24'h800000 :
                    24'($random(seed)), 1'b1);
            idle();
            repeat (6) @(posedge sys_clk);
        end
        // Disable, standby and power-down with a result in flight
        g_v = 2'b00;
        wr(8'h83, 16'h8010);
        for (int m = 0; m < 3; m++) begin
            raw(24'($random(seed)), 1'b1);
            idle();
            repeat (6) @(posedge sys_clk);
            raw(24'($random(seed)), 1'b0);
            idle();
            standby_mode <= (m == 1);
            power_down_mode <= (m == 2);
            if (m == 0) wr(8'h83, 16'h0010);
            raw(24'($random(seed)), 1'b0);
            idle();
            repeat (6) @(posedge sys_clk);
            #1 check({on_w, cnt_w, conv_data}, {m != 0, 26'h0});
            cnt_exp = 2'b00;
            @(posedge sys_clk);
            {standby_mode, power_down_mode} <= 2'b00;
            wr(8'h83, 16'h8010);
            raw(24'($random(seed)), 1'b1);
            idle();
            repeat (6) @(posedge sys_clk);
        end
        // Status: count, enable and sticky saturation, then its clear
        rd(8'hf0, {12'h000, cnt_exp, 2'b11});
        wr(8'hf0, 16'h0001);
        rd(8'hf0, {12'h000, cnt_exp, 2'b10});
        repeat (4) @(posedge sys_clk);
        end_of_test();
    end
endmodule // tb_shct_setup_trim

`default_nettype wire
